// [core/lalm_pkg.sv]
// Register map, field layout and constants of the lane alignment link monitor control
`default_nettype none
package lalm_pkg;
    // Register offsets on the management port
    localparam logic [4:0] LALM_ADDR_SLAVE_CFG = 5'h0c;
    localparam logic [4:0] LALM_ADDR_TIMER_CFG = 5'h0d;
    localparam logic [4:0] LALM_ADDR_RESET_CTL = 5'h0e;
    localparam logic [4:0] LALM_ADDR_MON_STATUS = 5'h1e;
    // Reset values
    localparam logic [15:0] LALM_SLAVE_CFG_RST = 16'h03f0;
    localparam logic [15:0] LALM_TIMER_CFG_RST = 16'hffff;
    localparam logic [15:0] LALM_RESET_CTL_RST = 16'h0000;
    // Field positions in lane_align_slave_config
    localparam int LALM_LANE_SEL_LSB = 12;
    localparam int LALM_HYS_SEL_LSB = 10;
    localparam int LALM_SPACING_LSB = 8;
    localparam int LALM_DEC_MASK_BIT = 7;
    localparam int LALM_LOS_MASK_BIT = 5;
    localparam int LALM_PLL_MASK_BIT = 4;
    localparam int LALM_REALIGN_BIT = 2;
    localparam int LALM_THRESH_LSB = 0;
    // Field positions in channel_reset_control
    localparam int LALM_DP_RST_BIT = 3;
    localparam int LALM_TXF_RST_BIT = 2;
    localparam int LALM_RXF_RST_BIT = 1;
    // Writable bits of the slave config and reset control registers
    localparam logic [15:0] LALM_SLAVE_CFG_WMASK = 16'h3ff7;
    localparam logic [15:0] LALM_RESET_CTL_WMASK = 16'h000e;
    // Alignment character spacing per code
    localparam logic [4:0] LALM_SPACING_0 = 5'h08;
    localparam logic [4:0] LALM_SPACING_1 = 5'h10;
    localparam logic [4:0] LALM_SPACING_2 = 5'h18;
    // Error count thresholds per code
    localparam int LALM_ERR_W = 11;
    localparam logic [10:0] LALM_THRESH_0 = 11'h001;
    localparam logic [10:0] LALM_THRESH_1 = 11'h00f;
    localparam logic [10:0] LALM_THRESH_2 = 11'h07f;
    localparam logic [10:0] LALM_THRESH_3 = 11'h3ff;
endpackage
`default_nettype wire

// [core/lalm_ctrl.sv]
// Management registers and link status monitor of one lane alignment channel
`default_nettype none
// Function
// - Lane select code picks shown alignment status
// - Hysteresis 00 uses standard sync loss
// - Hysteresis 1-3 drops sync after adjacent errors
// - Spacing code gives 8, 16, 24 characters
// - Unmasked decode errors at or over threshold drop link
// - Unmasked lane signal loss drops link
// - Unmasked PLL unlock drops link
// - Writing force bit restarts lane realignment
// - Self-clearing bits return to zero next cycle
// - Timer expiry: link ok if count below threshold
// - Programmable 16-bit timer sets checking interval
// - Datapath reset clears channel logic, keeps registers
// - Transmit FIFO reset touches only transmit FIFO
// - Receive FIFO reset touches only receive FIFO
module lalm_ctrl #(
    parameter int LANES = 4
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Management register port
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_rd,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    // Alignment slave and channel sync
    input wire logic [LANES-1:0] lane_align_status,
    input wire logic sym_valid,
    input wire logic sym_error,
    input wire logic std_sync_loss,
    output logic lane_status_view,
    output logic sync_loss,
    output logic [4:0] align_char_spacing,
    // Link status inputs
    input wire logic ber_check_en,
    input wire logic [LANES-1:0] lane_enable,
    input wire logic [LANES-1:0] decode_error,
    input wire logic [LANES-1:0] signal_loss,
    input wire logic pll_locked,
    output logic link_ok,
    // Channel control pulses
    output logic force_realignment,
    output logic datapath_reset,
    output logic transmit_fifo_reset,
    output logic receive_fifo_reset
);
    import lalm_pkg::*;

    if (LANES != 4) begin : g_lanes_check
        $error("lalm_ctrl serves exactly four lanes");
    end

    logic [15:0] slave_cfg;
    logic [15:0] timer_cfg;
    logic [15:0] reset_ctl;
    logic [15:0] ber_timer;
    logic [LALM_ERR_W-1:0] err_count;
    logic ber_ok;
    logic [1:0] adj_errors;
    logic [15:0] next_rdata;

    function automatic logic [LALM_ERR_W-1:0] thresh_of(input logic [1:0] code);
        case (code)
            2'h0: thresh_of = LALM_THRESH_0;
            2'h1: thresh_of = LALM_THRESH_1;
            2'h2: thresh_of = LALM_THRESH_2;
            default: thresh_of = LALM_THRESH_3;
        endcase
    endfunction

    wire logic wr_slave = ce && mgmt_wr && mgmt_addr == LALM_ADDR_SLAVE_CFG;
    wire logic wr_timer = ce && mgmt_wr && mgmt_addr == LALM_ADDR_TIMER_CFG;
    wire logic wr_reset = ce && mgmt_wr && mgmt_addr == LALM_ADDR_RESET_CTL;
    wire logic [1:0] hys_sel = slave_cfg[LALM_HYS_SEL_LSB +: 2];
    wire logic [1:0] thresh_sel = slave_cfg[LALM_THRESH_LSB +: 2];
    wire logic dp_rst = reset_ctl[LALM_DP_RST_BIT];
    wire logic realign = slave_cfg[LALM_REALIGN_BIT];
    wire logic timer_expire = ber_check_en && ber_timer == 16'h0000;
    wire logic any_dec_err = |(decode_error & lane_enable);
    wire logic any_los = |(signal_loss & lane_enable);
    wire logic sel_lane_status = lane_align_status[slave_cfg[LALM_LANE_SEL_LSB +: 2]];

    // Configuration register with self-clearing realign bit
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slave_cfg <= LALM_SLAVE_CFG_RST;
        end else if (wr_slave) begin
            slave_cfg <= mgmt_wdata & LALM_SLAVE_CFG_WMASK;
        end else if (ce) begin
            slave_cfg[LALM_REALIGN_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            timer_cfg <= LALM_TIMER_CFG_RST;
        end else if (wr_timer) begin
            timer_cfg <= mgmt_wdata;
        end
    end

    // Reset control bits all clear themselves one cycle after being set
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reset_ctl <= LALM_RESET_CTL_RST;
        end else if (wr_reset) begin
            reset_ctl <= mgmt_wdata & LALM_RESET_CTL_WMASK;
        end else if (ce) begin
            reset_ctl <= LALM_RESET_CTL_RST;
        end
    end

    // Register reads, unmapped offsets answer zero
    always_comb begin
        case (mgmt_addr)
            LALM_ADDR_SLAVE_CFG: next_rdata = slave_cfg;
            LALM_ADDR_TIMER_CFG: next_rdata = timer_cfg;
            LALM_ADDR_RESET_CTL: next_rdata = reset_ctl;
            LALM_ADDR_MON_STATUS: next_rdata = {link_ok, ber_ok, sync_loss, 2'h0, err_count};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else if (ce) begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd) begin
                mgmt_rdata <= next_rdata;
            end
        end
    end

    // Control pulses follow the self-clearing bits
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            force_realignment <= 1'b0;
            datapath_reset <= 1'b0;
            transmit_fifo_reset <= 1'b0;
            receive_fifo_reset <= 1'b0;
        end else if (ce) begin
            force_realignment <= realign;
            datapath_reset <= dp_rst;
            transmit_fifo_reset <= reset_ctl[LALM_TXF_RST_BIT];
            receive_fifo_reset <= reset_ctl[LALM_RXF_RST_BIT];
        end
    end

    // Status lane view and alignment spacing
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lane_status_view <= 1'b0;
            align_char_spacing <= LALM_SPACING_2;
        end else if (ce) begin
            lane_status_view <= sel_lane_status;
            case (slave_cfg[LALM_SPACING_LSB +: 2])
                2'h0: align_char_spacing <= LALM_SPACING_0;
                2'h1: align_char_spacing <= LALM_SPACING_1;
                default: align_char_spacing <= LALM_SPACING_2;
            endcase
        end
    end

    // Channel sync loss with selectable hysteresis
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            adj_errors <= 2'h0;
            sync_loss <= 1'b0;
        end else if (ce) begin
            if (dp_rst) begin
                adj_errors <= 2'h0;
                sync_loss <= 1'b0;
            end else if (hys_sel == 2'h0) begin
                adj_errors <= 2'h0;
                sync_loss <= std_sync_loss;
            end else if (sym_valid && sym_error) begin
                if (adj_errors + 2'h1 >= hys_sel) begin
                    adj_errors <= 2'h0;
                    sync_loss <= 1'b1;
                end else begin
                    adj_errors <= adj_errors + 2'h1;
                    sync_loss <= 1'b0;
                end
            end else begin
                if (sym_valid) begin
                    adj_errors <= 2'h0;
                end
                sync_loss <= 1'b0;
            end
        end
    end

    // Error-rate timer and error count
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ber_timer <= LALM_TIMER_CFG_RST;
            err_count <= '0;
            ber_ok <= 1'b1;
        end else if (ce) begin
            if (dp_rst || realign || !ber_check_en) begin
                ber_timer <= timer_cfg;
                err_count <= '0;
                ber_ok <= 1'b1;
            end else if (timer_expire) begin
                ber_ok <= err_count < thresh_of(thresh_sel);
                ber_timer <= timer_cfg;
                err_count <= '0;
            end else begin
                ber_timer <= ber_timer - 16'h0001;
                if (any_dec_err && err_count != '1) begin
                    err_count <= err_count + 1'b1;
                end
            end
        end
    end

    // Link status from the unmasked sources
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            link_ok <= 1'b0;
        end else if (ce) begin
            link_ok <= (slave_cfg[LALM_DEC_MASK_BIT] || !ber_check_en || ber_ok)
                && (slave_cfg[LALM_LOS_MASK_BIT] || !any_los)
                && (slave_cfg[LALM_PLL_MASK_BIT] || pll_locked);
        end
    end

    // Checks
    sequence s_realign_write;
        wr_slave && mgmt_wdata[LALM_REALIGN_BIT];
    endsequence

    a_realign_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        s_realign_write ##1 ce |-> ##1 force_realignment)
        else $error("force realign write gave no pulse");
    a_sc_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(dp_rst) && ce && !wr_reset |=> !dp_rst)
        else $error("datapath reset bit did not self clear");
    a_lane_view: assert property (@(posedge core_clk) disable iff (!rstn)
        ce |=> lane_status_view == $past(sel_lane_status))
        else $error("lane status view mismatch");
    a_spacing_map: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && slave_cfg[9:8] == 2'h1 |=> align_char_spacing == 5'h10)
        else $error("alignment spacing wrong");
    a_hys_single: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !dp_rst && hys_sel == 2'h1 && sym_valid && sym_error |=> sync_loss)
        else $error("single error did not drop sync");
    a_hys_std: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !dp_rst && hys_sel == 2'h0 |=> sync_loss == $past(std_sync_loss))
        else $error("standard sync loss not followed");
    a_ber_verdict: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !dp_rst && !realign && timer_expire |=>
            ber_ok == ($past(err_count) < thresh_of($past(thresh_sel))))
        else $error("error rate verdict wrong");
    a_timer_reload: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !dp_rst && !realign && timer_expire |=> err_count == '0 &&
            ber_timer == $past(timer_cfg))
        else $error("timer expiry did not reload");
    a_pll_mask: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !slave_cfg[LALM_PLL_MASK_BIT] && !pll_locked |=> !link_ok)
        else $error("unmasked pll unlock kept link");
    a_los_mask: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !slave_cfg[LALM_LOS_MASK_BIT] && any_los |=> !link_ok)
        else $error("unmasked signal loss kept link");
    a_dec_mask: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && !slave_cfg[LALM_DEC_MASK_BIT] && ber_check_en && !ber_ok |=> !link_ok)
        else $error("unmasked error rate kept link");
    a_fifo_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && reset_ctl[LALM_TXF_RST_BIT] && !reset_ctl[LALM_RXF_RST_BIT] && !dp_rst |=>
            transmit_fifo_reset && !receive_fifo_reset && !datapath_reset)
        else $error("transmit fifo reset pulse wrong");
    a_rxf_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && reset_ctl[LALM_RXF_RST_BIT] && !reset_ctl[LALM_TXF_RST_BIT] && !dp_rst |=>
            receive_fifo_reset && !transmit_fifo_reset && !datapath_reset)
        else $error("receive fifo reset pulse wrong");
    a_realign_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && realign && !wr_slave |=> !realign)
        else $error("realign bit did not self clear");
    a_dp_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && dp_rst && !wr_timer |=> datapath_reset && !sync_loss && err_count == '0 &&
            timer_cfg == $past(timer_cfg))
        else $error("datapath reset pulse or state clear wrong");
    a_timer_read: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && mgmt_rd && mgmt_addr == LALM_ADDR_TIMER_CFG |=> mgmt_rvalid && mgmt_rdata == $past(timer_cfg))
        else $error("timer register read wrong");
    a_timer_count: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && ber_check_en && !dp_rst && !realign && !timer_expire |=> ber_timer == $past(ber_timer) - 16'h0001)
        else $error("error rate timer did not count down");

    // Two errors on back to back valid symbols under hysteresis 10
    sequence s_hys2_err;
        ce && !dp_rst && hys_sel == 2'h2 && sym_valid && sym_error;
    endsequence
    sequence s_hys2_pair;
        s_hys2_err ##1 s_hys2_err;
    endsequence

    a_hys_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        adj_errors == 2'h0 ##0 s_hys2_pair |=> sync_loss)
        else $error("two adjacent errors did not drop sync");
endmodule
`default_nettype wire

// [sim/lalm_uplink_model.sv]
// Uplink partner model: drives the lane side of one channel on request
`default_nettype none
module lalm_uplink_model (
    // Requests from the test sequence
    input wire logic [3:0] align_req,
    input wire logic sym_err_req,
    input wire logic sym_gap_req,
    input wire logic std_loss_req,
    input wire logic dec_err_req,
    input wire logic [3:0] loss_req,
    input wire logic unlock_req,
    // Lane side of the channel
    output logic [3:0] lane_align_status,
    output logic sym_valid,
    output logic sym_error,
    output logic std_sync_loss,
    output logic [3:0] decode_error,
    output logic [3:0] signal_loss,
    output logic pll_locked
);
    timeunit 1ns;
    timeprecision 100ps;
    // A symbol arrives every cycle unless a gap is asked for; faults only on request
    assign sym_valid = ~sym_gap_req;
    assign sym_error = sym_err_req;
    assign lane_align_status = align_req;
    assign std_sync_loss = std_loss_req;
    assign decode_error = {4{dec_err_req}};
    assign signal_loss = loss_req;
    assign pll_locked = ~unlock_req;
endmodule
`default_nettype wire

// [sim/test_lalm_ctrl.sv]
// Register and link monitor tests of the lane alignment channel control
`default_nettype none
module test_lalm_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import lalm_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] mgmt_addr = 5'h00;
    logic mgmt_wr = 1'b0;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic mgmt_rd = 1'b0;
    logic [15:0] mgmt_rdata;
    logic mgmt_rvalid;
    logic [3:0] align_req = 4'hf;
    logic sym_err_req = 1'b0;
    logic sym_gap_req = 1'b0;
    logic ce = 1'b1;
    logic [3:0] lane_en = 4'hf;
    logic std_loss_req = 1'b0;
    logic dec_err_req = 1'b0;
    logic [3:0] loss_req = 4'h0;
    logic unlock_req = 1'b0;
    logic ber_en = 1'b0;
    logic [3:0] lane_align_status, decode_error, signal_loss;
    logic sym_valid, sym_error, std_sync_loss, pll_locked;
    logic lane_status_view, sync_loss, link_ok;
    logic force_realignment, datapath_reset, transmit_fifo_reset, receive_fifo_reset;
    logic [4:0] align_char_spacing;
    logic [4:0] spc [4] = '{5'h08, 5'h10, 5'h18, 5'h18};
    int error_cnt = 0;
    int num_checks = 0;

    always #2.5 core_clk = ~core_clk;

    lalm_uplink_model i_model (.align_req(align_req), .sym_err_req(sym_err_req),
        .sym_gap_req(sym_gap_req),
        .std_loss_req(std_loss_req), .dec_err_req(dec_err_req), .loss_req(loss_req),
        .unlock_req(unlock_req), .lane_align_status(lane_align_status),
        .sym_valid(sym_valid), .sym_error(sym_error), .std_sync_loss(std_sync_loss),
        .decode_error(decode_error), .signal_loss(signal_loss), .pll_locked(pll_locked));

    lalm_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .lane_align_status(lane_align_status), .sym_valid(sym_valid),
        .sym_error(sym_error), .std_sync_loss(std_sync_loss),
        .lane_status_view(lane_status_view), .sync_loss(sync_loss),
        .align_char_spacing(align_char_spacing), .ber_check_en(ber_en),
        .lane_enable(lane_en), .decode_error(decode_error), .signal_loss(signal_loss),
        .pll_locked(pll_locked), .link_ok(link_ok), .force_realignment(force_realignment),
        .datapath_reset(datapath_reset), .transmit_fifo_reset(transmit_fifo_reset),
        .receive_fifo_reset(receive_fifo_reset));

    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = 1'b1;
        tick();
        mgmt_wr = 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        tick();
        mgmt_rd = 1'b0;
        check(mgmt_rvalid, 16'h0001);
        check(mgmt_rdata, exp);
        tick();
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100us;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        #1 rstn = 1'b1;
        tick();
        check(align_char_spacing, 16'h0018);
        rd(LALM_ADDR_SLAVE_CFG, 16'h03f0);
        rd(LALM_ADDR_TIMER_CFG, 16'hffff);
        rd(LALM_ADDR_RESET_CTL, 16'h0000);
        rd(5'h00, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(LALM_ADDR_SLAVE_CFG, 16'h03f0 | (16'(k) << 12));
            align_req = 4'h1 << k;
            tick(2);
            check(lane_status_view, 16'h0001);
            align_req = ~(4'h1 << k);
            tick(2);
            check(lane_status_view, 16'h0000);
        end
        align_req = 4'hf;
        for (int k = 0; k < 4; k++) begin
            wr(LALM_ADDR_SLAVE_CFG, 16'h00f0 | (16'(k) << 8));
            tick(2);
            check(align_char_spacing, spc[k]);
        end
        for (int n = 1; n <= 3; n++) begin
            wr(LALM_ADDR_SLAVE_CFG, 16'h03f0 | (16'(n) << 10));
            tick(2);
            for (int k = 1; k <= n; k++) begin
                sym_err_req = 1'b1;
                if (n == 3) begin
                    // An idle symbol slot between errors keeps them adjacent
                    sym_gap_req = 1'b1;
                    tick();
                    check(sync_loss, 16'h0000);
                    sym_gap_req = 1'b0;
                end
                tick();
                check(sync_loss, 16'(k == n));
            end
            sym_err_req = 1'b0;
            tick();
            check(sync_loss, 16'h0000);
        end
        wr(LALM_ADDR_SLAVE_CFG, 16'h03f0);
        std_loss_req = 1'b1;
        tick(2);
        check(sync_loss, 16'h0001);
        std_loss_req = 1'b0;
        tick(2);
        check(sync_loss, 16'h0000);
        wr(LALM_ADDR_SLAVE_CFG, 16'h3ff7);
        tick();
        check(force_realignment, 16'h0001);
        tick();
        check(force_realignment, 16'h0000);
        rd(LALM_ADDR_SLAVE_CFG, 16'h3ff3);
        wr(LALM_ADDR_SLAVE_CFG, 16'h0300);
        tick(3);
        check(link_ok, 16'h0001);
        loss_req = 4'h4;
        tick(3);
        check(link_ok, 16'h0000);
        lane_en = 4'hb;
        tick(3);
        check(link_ok, 16'h0001);
        lane_en = 4'hf;
        loss_req = 4'h0;
        unlock_req = 1'b1;
        tick(3);
        check(link_ok, 16'h0000);
        wr(LALM_ADDR_SLAVE_CFG, 16'h0330);
        tick(3);
        check(link_ok, 16'h0001);
        unlock_req = 1'b0;
        // Short checking interval of 32 cycles keeps the run brief
        wr(LALM_ADDR_TIMER_CFG, 16'h001f);
        tick();
        wr(LALM_ADDR_SLAVE_CFG, 16'h0301);
        ber_en = 1'b1;
        dec_err_req = 1'b1;
        tick(14);
        dec_err_req = 1'b0;
        tick(70);
        check(link_ok, 16'h0001);
        dec_err_req = 1'b1;
        tick(70);
        check(link_ok, 16'h0000);
        dec_err_req = 1'b0;
        tick(70);
        check(link_ok, 16'h0001);
        wr(LALM_ADDR_SLAVE_CFG, 16'h0381);
        dec_err_req = 1'b1;
        tick(70);
        check(link_ok, 16'h0001);
        dec_err_req = 1'b0;
        // Datapath reset last, once the mode is configured
        for (int b = 1; b <= 3; b++) begin
            wr(LALM_ADDR_RESET_CTL, 16'h0001 << b);
            tick();
            check({datapath_reset, transmit_fifo_reset, receive_fifo_reset}, 3'b001 << (b - 1));
            tick();
            check({datapath_reset, transmit_fifo_reset, receive_fifo_reset}, 16'h0000);
        end
        // Writes while the clock enable is low must not land
        ce = 1'b0;
        wr(LALM_ADDR_TIMER_CFG, 16'h1234);
        ce = 1'b1;
        rd(LALM_ADDR_RESET_CTL, 16'h0000);
        rd(LALM_ADDR_TIMER_CFG, 16'h001f);
        rd(LALM_ADDR_MON_STATUS, 16'hc000);
        summarize();
    end
endmodule
`default_nettype wire
